// [hdl/mwm_top.v]
// Motion window monitor: drive objects, window comparisons and status bits
//
// Contract
// - Internal actual position is a signed 32-bit encoder count that homing does not zero.
// - With zero encoder resolution the internal position is flagged invalid and reads as zero.
// - Status bit 13 rises once the position gap exceeds the following-error window longer than the timeout in ms.
// - The following-error window is applied as one limit on either side of the demand position.
// - An all-ones following-error window disables the check and keeps bit 13 low.
// - With a reaction configured, a following error triggers the reaction and an error history entry.
// - In profile or interpolated position mode bit 10 rises once inside the target window longer than its time.
// - The position window is applied as one limit on either side of the target position.
// - An all-ones position window disables target-position monitoring.
// - The position window time is counted in ms and must pass in full inside the window.
// - The velocity demand object shows the ramp output, which is also the velocity controller set point.
// - In profile velocity mode bit 10 rises once the speed stays in the velocity window longer than its time.
// - The velocity window time is counted in ms and must pass in full inside the window.
// - Bit 12 drops to zero while speed has exceeded the threshold for the threshold time, else it reads one.
// - The threshold time is counted in ms and speed counts as nonzero only in profile velocity mode.
`timescale 1ns/100ps
`default_nettype none
`include "mwm_regs.vh"
module mwm_top #(
   parameter integer MS_CYCLES = `MWM_MS_CYCLES
) (
   input wire clk_sys_i,
   input wire rst_i,
   // Object access port
   input wire obj_req_i,
   input wire obj_we_i,
   input wire [15:0] obj_index_i,
   input wire [31:0] obj_wdata_i,
   output reg obj_ack_o,
   output reg obj_err_o,
   output reg [31:0] obj_rdata_o,
   // Motion values from the rest of the drive
   input wire [7:0] op_mode_i,
   input wire homing_done_i,
   input wire enc_res_zero_i,
   input wire [31:0] pos_demand_i,
   input wire [31:0] pos_act_raw_i,
   input wire [31:0] pos_actual_i,
   input wire [31:0] pos_target_i,
   input wire [31:0] ramp_vel_i,
   input wire [31:0] vel_actual_i,
   input wire [31:0] vel_target_i,
   input wire [15:0] ferr_react_cfg_i,
   // Results
   output reg [15:0] status_o,
   output reg pos_raw_valid_o,
   output reg [31:0] vel_setpoint_o,
   output reg ferr_react_o,
   output reg err_log_o
);
   // Object storage
   reg [31:0] pos_demand_q;
   reg [31:0] pos_act_raw_q;
   reg [31:0] pos_actual_q;
   reg [31:0] vel_demand_q;
   reg [31:0] vel_actual_q;
   reg [31:0] ferr_window_q;
   reg [15:0] ferr_timeout_q;
   reg [31:0] pos_window_q;
   reg [15:0] pos_win_time_q;
   reg [15:0] vel_window_q;
   reg [15:0] vel_win_time_q;
   reg [15:0] vel_thresh_q;
   reg [15:0] vel_thr_time_q;

   // Comparison terms
   reg [32:0] ferr_diff;
   reg [32:0] ferr_abs;
   reg [32:0] pos_diff;
   reg [32:0] pos_abs;
   reg [32:0] vel_diff;
   reg [32:0] vel_abs;
   reg [31:0] spd_abs;
   wire ferr_en;
   wire pos_en;
   wire pos_mode;
   wire vel_mode;
   wire ferr_cond;
   wire pos_cond;
   wire vel_cond;
   wire nz_cond;
   wire ferr_hit;
   wire pos_hit;
   wire vel_hit;
   wire nz_hit;
   wire tick;
   wire ferr_bit;
   reg ferr_bit_q;

   // Mode-gated hits and the status word ahead of its register
   wire pos_bit;
   wire vel_bit;
   wire nz_bit;
   wire ferr_new;
   reg [15:0] status_d;

   reg [31:0] rd_d;
   reg rd_err_d;
   reg wr_err_d;

   mwm_tick #(
      .CYCLES(MS_CYCLES)
   ) u_tick (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .tick_o(tick)
   );

   // Process values: user-unit positions zero on homing, internal one keeps counting
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         pos_demand_q <= 32'h0000_0000;
         pos_act_raw_q <= 32'h0000_0000;
         pos_actual_q <= 32'h0000_0000;
         vel_demand_q <= 32'h0000_0000;
         vel_actual_q <= 32'h0000_0000;
         vel_setpoint_o <= 32'h0000_0000;
         pos_raw_valid_o <= 1'b0;
      end else begin
         pos_act_raw_q <= pos_act_raw_i;
         pos_raw_valid_o <= !enc_res_zero_i;
         if (homing_done_i) begin
            pos_demand_q <= 32'h0000_0000;
            pos_actual_q <= 32'h0000_0000;
         end else begin
            pos_demand_q <= pos_demand_i;
            pos_actual_q <= pos_actual_i;
         end
         vel_demand_q <= ramp_vel_i;
         vel_setpoint_o <= ramp_vel_i;
         vel_actual_q <= vel_actual_i;
      end
   end

   // Absolute deviations on 33 bits so the full signed range never overflows
   always @* begin
      ferr_diff = {pos_actual_q[31], pos_actual_q} - {pos_demand_q[31], pos_demand_q};
      ferr_abs = ferr_diff[32] ? (33'h0_0000_0000 - ferr_diff) : ferr_diff;
      pos_diff = {pos_actual_q[31], pos_actual_q} - {pos_target_i[31], pos_target_i};
      pos_abs = pos_diff[32] ? (33'h0_0000_0000 - pos_diff) : pos_diff;
      vel_diff = {vel_actual_q[31], vel_actual_q} - {vel_target_i[31], vel_target_i};
      vel_abs = vel_diff[32] ? (33'h0_0000_0000 - vel_diff) : vel_diff;
      spd_abs = vel_actual_q[31] ? (32'h0000_0000 - vel_actual_q) : vel_actual_q;
   end

   assign ferr_en = (ferr_window_q != `MWM_WINDOW_OFF);
   assign pos_en = (pos_window_q != `MWM_WINDOW_OFF);
   assign pos_mode = (op_mode_i == `MWM_MODE_PP) || (op_mode_i == `MWM_MODE_IP);
   assign vel_mode = (op_mode_i == `MWM_MODE_PV);
   assign ferr_cond = ferr_en && (ferr_abs > {1'b0, ferr_window_q});
   assign pos_cond = pos_en && pos_mode && (pos_abs < {1'b0, pos_window_q});
   assign vel_cond = vel_mode && (vel_abs < {17'h0_0000, vel_window_q});
   // Slow speed test in other modes would clear bit 12 where it has no meaning
   assign nz_cond = vel_mode && (spd_abs > {16'h0000, vel_thresh_q});

   mwm_persist u_ferr (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .cond_i(ferr_cond),
      .time_ms_i(ferr_timeout_q),
      .hit_o(ferr_hit)
   );

   mwm_persist u_pos (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .cond_i(pos_cond),
      .time_ms_i(pos_win_time_q),
      .hit_o(pos_hit)
   );

   mwm_persist u_vel (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .cond_i(vel_cond),
      .time_ms_i(vel_win_time_q),
      .hit_o(vel_hit)
   );

   mwm_persist u_nz (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .cond_i(nz_cond),
      .time_ms_i(vel_thr_time_q),
      .hit_o(nz_hit)
   );

   assign ferr_bit = ferr_hit && ferr_en;
   // Live mode gates each hit, and pos_en also the position hit, so a stale timer never outlives a mode change
   assign pos_bit = pos_hit && pos_en && pos_mode;
   assign vel_bit = vel_hit && vel_mode;
   assign nz_bit = nz_hit && vel_mode;
   // Rising edge only, a standing error must not flood the history
   assign ferr_new = ferr_bit && !ferr_bit_q && (ferr_react_cfg_i != 16'h0000);

   // Bits other than 10, 12 and 13 are not ours and read zero
   always @* begin
      status_d = 16'h0000;
      status_d[`MWM_SW_FERR_BIT] = ferr_bit;
      status_d[`MWM_SW_TARGET_BIT] = pos_bit || vel_bit;
      status_d[`MWM_SW_NONZERO_BIT] = !nz_bit;
   end

   // Status bits and following-error reaction
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         status_o <= 16'h1000;
         ferr_bit_q <= 1'b0;
         ferr_react_o <= 1'b0;
         err_log_o <= 1'b0;
      end else begin
         status_o <= status_d;
         ferr_bit_q <= ferr_bit;
         // Reaction and history entry always travel together
         ferr_react_o <= ferr_new;
         err_log_o <= ferr_new;
      end
   end

   // Object read decode
   always @* begin
      rd_d = 32'h0000_0000;
      rd_err_d = 1'b0;
      case (obj_index_i)
         `MWM_IDX_POS_DEMAND: rd_d = pos_demand_q;
         // Invalid count hidden rather than shown as a number
         `MWM_IDX_POS_ACT_RAW: rd_d = enc_res_zero_i ? 32'h0000_0000 : pos_act_raw_q;
         `MWM_IDX_POS_ACTUAL: rd_d = pos_actual_q;
         `MWM_IDX_FERR_WINDOW: rd_d = ferr_window_q;
         `MWM_IDX_FERR_TIMEOUT: rd_d = {16'h0000, ferr_timeout_q};
         `MWM_IDX_POS_WINDOW: rd_d = pos_window_q;
         `MWM_IDX_POS_WIN_TIME: rd_d = {16'h0000, pos_win_time_q};
         `MWM_IDX_VEL_DEMAND: rd_d = vel_demand_q;
         `MWM_IDX_VEL_ACTUAL: rd_d = vel_actual_q;
         `MWM_IDX_VEL_WINDOW: rd_d = {16'h0000, vel_window_q};
         `MWM_IDX_VEL_WIN_TIME: rd_d = {16'h0000, vel_win_time_q};
         `MWM_IDX_VEL_THRESH: rd_d = {16'h0000, vel_thresh_q};
         `MWM_IDX_VEL_THR_TIME: rd_d = {16'h0000, vel_thr_time_q};
         default: rd_err_d = 1'b1;
      endcase
   end

   // Writes to read-only or unknown objects are refused
   always @* begin
      case (obj_index_i)
         `MWM_IDX_FERR_WINDOW: wr_err_d = 1'b0;
         `MWM_IDX_FERR_TIMEOUT: wr_err_d = 1'b0;
         `MWM_IDX_POS_WINDOW: wr_err_d = 1'b0;
         `MWM_IDX_POS_WIN_TIME: wr_err_d = 1'b0;
         `MWM_IDX_VEL_WINDOW: wr_err_d = 1'b0;
         `MWM_IDX_VEL_WIN_TIME: wr_err_d = 1'b0;
         `MWM_IDX_VEL_THRESH: wr_err_d = 1'b0;
         `MWM_IDX_VEL_THR_TIME: wr_err_d = 1'b0;
         default: wr_err_d = 1'b1;
      endcase
   end

   // Parameter objects and access answer
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         ferr_window_q <= `MWM_RST_FERR_WINDOW;
         ferr_timeout_q <= `MWM_RST_FERR_TIMEOUT;
         pos_window_q <= `MWM_RST_POS_WINDOW;
         pos_win_time_q <= `MWM_RST_POS_WIN_TIME;
         vel_window_q <= `MWM_RST_VEL_WINDOW;
         vel_win_time_q <= `MWM_RST_VEL_WIN_TIME;
         vel_thresh_q <= `MWM_RST_VEL_THRESH;
         vel_thr_time_q <= `MWM_RST_VEL_THR_TIME;
         obj_ack_o <= 1'b0;
         obj_err_o <= 1'b0;
         obj_rdata_o <= 32'h0000_0000;
      end else begin
         obj_ack_o <= obj_req_i;
         obj_err_o <= obj_req_i && (obj_we_i ? wr_err_d : rd_err_d);
         if (obj_req_i && !obj_we_i) begin
            obj_rdata_o <= rd_d;
         end
         if (obj_req_i && obj_we_i) begin
            case (obj_index_i)
               `MWM_IDX_FERR_WINDOW: ferr_window_q <= obj_wdata_i;
               `MWM_IDX_FERR_TIMEOUT: ferr_timeout_q <= obj_wdata_i[15:0];
               `MWM_IDX_POS_WINDOW: pos_window_q <= obj_wdata_i;
               `MWM_IDX_POS_WIN_TIME: pos_win_time_q <= obj_wdata_i[15:0];
               `MWM_IDX_VEL_WINDOW: vel_window_q <= obj_wdata_i[15:0];
               `MWM_IDX_VEL_WIN_TIME: vel_win_time_q <= obj_wdata_i[15:0];
               `MWM_IDX_VEL_THRESH: vel_thresh_q <= obj_wdata_i[15:0];
               `MWM_IDX_VEL_THR_TIME: vel_thr_time_q <= obj_wdata_i[15:0];
               default: ferr_window_q <= ferr_window_q;
            endcase
         end
      end
   end
endmodule // mwm_top
`default_nettype wire

// [pkg/mwm_regs.vh]
// Object indices, reset values, status bits and timing counts of the motion window monitor
`ifndef MWM_REGS_VH
`define MWM_REGS_VH

`define MWM_IDX_POS_DEMAND 16'h6062
`define MWM_IDX_POS_ACT_RAW 16'h6063
`define MWM_IDX_POS_ACTUAL 16'h6064
`define MWM_IDX_FERR_WINDOW 16'h6065
`define MWM_IDX_FERR_TIMEOUT 16'h6066
`define MWM_IDX_POS_WINDOW 16'h6067
`define MWM_IDX_POS_WIN_TIME 16'h6068
`define MWM_IDX_VEL_DEMAND 16'h606B
`define MWM_IDX_VEL_ACTUAL 16'h606C
`define MWM_IDX_VEL_WINDOW 16'h606D
`define MWM_IDX_VEL_WIN_TIME 16'h606E
`define MWM_IDX_VEL_THRESH 16'h606F
`define MWM_IDX_VEL_THR_TIME 16'h6070

`define MWM_RST_FERR_WINDOW 32'h0000_0100
`define MWM_RST_FERR_TIMEOUT 16'h0064
`define MWM_RST_POS_WINDOW 32'h0000_000A
`define MWM_RST_POS_WIN_TIME 16'h0064
`define MWM_RST_VEL_WINDOW 16'h001E
`define MWM_RST_VEL_WIN_TIME 16'h0000
`define MWM_RST_VEL_THRESH 16'h0000
`define MWM_RST_VEL_THR_TIME 16'h0000

`define MWM_WINDOW_OFF 32'hFFFF_FFFF

`define MWM_SW_TARGET_BIT 10
`define MWM_SW_NONZERO_BIT 12
`define MWM_SW_FERR_BIT 13

`define MWM_MODE_PP 8'h01
`define MWM_MODE_PV 8'h03
`define MWM_MODE_IP 8'h07

`define MWM_CLK_NS 20
`define MWM_TICK_NS 1000000
`define MWM_MS_CYCLES (`MWM_TICK_NS / `MWM_CLK_NS)

`endif

// [hdl/mwm_tick.v]
// Millisecond tick generator for the persistence timers
`timescale 1ns/100ps
`default_nettype none
module mwm_tick #(
   parameter integer CYCLES = 50000
) (
   input wire clk_sys_i,
   input wire rst_i,
   output reg tick_o
);
   reg [31:0] cnt_q;

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         cnt_q <= 32'h0000_0000;
         tick_o <= 1'b0;
      end else if (cnt_q == CYCLES - 1) begin
         cnt_q <= 32'h0000_0000;
         tick_o <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 32'h0000_0001;
         tick_o <= 1'b0;
      end
   end
endmodule // mwm_tick
`default_nettype wire

// [hdl/mwm_persist.v]
// Persistence timer: flags a condition that held longer than a time in ms
`timescale 1ns/100ps
`default_nettype none
module mwm_persist (
   input wire clk_sys_i,
   input wire rst_i,
   input wire tick_i,
   input wire cond_i,
   input wire [15:0] time_ms_i,
   output reg hit_o
);
   reg [16:0] cnt_q;

   // Count stops once past the limit so a long hold never wraps
   always @(posedge clk_sys_i) begin
      if (rst_i || !cond_i) begin
         cnt_q <= 17'h0_0000;
         hit_o <= 1'b0;
      end else begin
         if (tick_i && !hit_o) begin
            cnt_q <= cnt_q + 17'h0_0001;
         end
         hit_o <= (cnt_q > {1'b0, time_ms_i});
      end
   end
endmodule // mwm_persist
`default_nettype wire

// [bench/mwm_top_sva.sv]
// Concurrent checks on the motion window monitor ports
`timescale 1ns/100ps
`default_nettype none
module mwm_top_sva (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic obj_req_i,
   input wire logic obj_ack_o,
   input wire logic [7:0] op_mode_i,
   input wire logic enc_res_zero_i,
   input wire logic [31:0] ramp_vel_i,
   input wire logic [15:0] ferr_react_cfg_i,
   input wire logic [15:0] status_o,
   input wire logic pos_raw_valid_o,
   input wire logic [31:0] vel_setpoint_o,
   input wire logic ferr_react_o,
   input wire logic err_log_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   sequence s_ferr_rise;
      $rose(status_o[13]) && $past(ferr_react_cfg_i) != 16'h0000;
   endsequence
   sequence s_no_pos_mode;
      (op_mode_i != 8'h01 && op_mode_i != 8'h03 && op_mode_i != 8'h07) [*3];
   endsequence
   // Past value is still a reset value on the first edge after release
   a_setpoint_copy: assert property (!$past(rst_i) |-> vel_setpoint_o == $past(ramp_vel_i))
      else $error("set point not the ramp output");
   a_raw_valid_flag: assert property (!$past(rst_i) |-> pos_raw_valid_o == !$past(enc_res_zero_i))
      else $error("raw position valid flag wrong");
   a_react_on_rise: assert property (s_ferr_rise |-> ferr_react_o && err_log_o)
      else $error("reaction or log missing");
   a_react_cause: assert property (ferr_react_o |-> $rose(status_o[13]))
      else $error("reaction without new following error");
   a_log_pairs_react: assert property (err_log_o |-> ferr_react_o ##1 !err_log_o)
      else $error("log entry not paired with reaction");
   a_react_gated_cfg: assert property ((ferr_react_cfg_i == 16'h0000) [*2] |-> !ferr_react_o)
      else $error("reaction without configuration");
   a_nonzero_pv_only: assert property ((op_mode_i != 8'h03) [*3] |-> status_o[12])
      else $error("speed nonzero outside velocity mode");
   a_target_mode: assert property (s_no_pos_mode |-> !status_o[10])
      else $error("target bit outside its modes");
   a_ack_next: assert property (obj_req_i |=> obj_ack_o ##1 (!obj_ack_o || $past(obj_req_i)))
      else $error("object access not answered");
endmodule // mwm_top_sva
bind mwm_top mwm_top_sva u_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .obj_req_i(obj_req_i),
   .obj_ack_o(obj_ack_o), .op_mode_i(op_mode_i), .enc_res_zero_i(enc_res_zero_i), .ramp_vel_i(ramp_vel_i),
   .ferr_react_cfg_i(ferr_react_cfg_i), .status_o(status_o), .pos_raw_valid_o(pos_raw_valid_o),
   .vel_setpoint_o(vel_setpoint_o), .ferr_react_o(ferr_react_o), .err_log_o(err_log_o));
`default_nettype wire

// [bench/mwm_host.sv]
// Fieldbus host model issuing object reads and writes
`timescale 1ns/100ps
`default_nettype none
module mwm_host (
   input wire logic clk_sys_i,
   input wire logic obj_ack_i,
   input wire logic obj_err_i,
   input wire logic [31:0] obj_rdata_i,
   output var logic obj_req_o,
   output var logic obj_we_o,
   output var logic [15:0] obj_index_o,
   output var logic [31:0] obj_wdata_o
);
   initial begin
      obj_req_o = 1'b0;
      obj_we_o = 1'b0;
      obj_index_o = 16'h0000;
      obj_wdata_o = 32'h0000_0000;
   end
   // One-cycle request as the port takes it; answer taken at the edge ack is sampled high
   task access(input logic we, input logic [15:0] idx, input logic [31:0] wd,
               output logic [31:0] rd, output logic err, output logic ack);
      @(posedge clk_sys_i);
      obj_req_o <= 1'b1;
      obj_we_o <= we;
      obj_index_o <= idx;
      obj_wdata_o <= wd;
      @(posedge clk_sys_i);
      obj_req_o <= 1'b0;
      // Released lines show junk, not the last value
      obj_index_o <= ~idx;
      obj_wdata_o <= ~wd;
      @(posedge clk_sys_i);
      rd = obj_rdata_i;
      err = obj_err_i;
      ack = obj_ack_i;
   endtask
endmodule // mwm_host
`default_nettype wire

// [bench/mwm_top_tb.sv]
// Self-checking testbench of the motion window monitor
`timescale 1ns/100ps
`default_nettype none
`include "mwm_regs.vh"
module mwm_top_tb;
   logic clk_sys_i, rst_i, req, we, ack, err, homing, enc_zero, raw_valid, react, log_e, a, e;
   logic [7:0] mode;
   logic [15:0] idx, cfg, status;
   logic [31:0] wd, rdata, pdem, praw, pact, ptgt, ramp, vact, vtgt, setp, r;
   int n_mismatch, checked;
   logic [15:0] ix [8] = '{16'h6065, 16'h6066, 16'h6067, 16'h6068, 16'h606D, 16'h606E, 16'h606F, 16'h6070};
   logic [31:0] rv [8] = '{32'h0000_0100, 32'h0000_0064, 32'h0000_000A, 32'h0000_0064,
                           32'h0000_001E, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
   mwm_top #(.MS_CYCLES(4)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .obj_req_i(req), .obj_we_i(we),
      .obj_index_i(idx), .obj_wdata_i(wd), .obj_ack_o(ack), .obj_err_o(err), .obj_rdata_o(rdata),
      .op_mode_i(mode), .homing_done_i(homing), .enc_res_zero_i(enc_zero), .pos_demand_i(pdem),
      .pos_act_raw_i(praw), .pos_actual_i(pact), .pos_target_i(ptgt), .ramp_vel_i(ramp), .vel_actual_i(vact),
      .vel_target_i(vtgt), .ferr_react_cfg_i(cfg), .status_o(status), .pos_raw_valid_o(raw_valid),
      .vel_setpoint_o(setp), .ferr_react_o(react), .err_log_o(log_e));
   mwm_host host (.clk_sys_i(clk_sys_i), .obj_ack_i(ack), .obj_err_i(err), .obj_rdata_i(rdata),
      .obj_req_o(req), .obj_we_o(we), .obj_index_o(idx), .obj_wdata_o(wd));
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   task give_verdict;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task acc(input logic w, input logic [15:0] i, input logic [31:0] d, input logic [31:0] xd, input logic xe);
      host.access(w, i, d, r, e, a);
      chk({a, e}, {1'b1, xe});
      if (!w) chk(r, xd);
   endtask
   // Bounded wait for a status bit, then compare
   task wait_bit(input int b, input logic v, input int n);
      for (int k = 0; k < n && status[b] !== v; k++) @(posedge clk_sys_i);
      chk(status[b], v);
   endtask
   initial begin
      #200000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      rst_i = 1'b1;
      {homing, enc_zero} = 2'b00;
      mode = `MWM_MODE_PP;
      cfg = 16'h0001;
      {pdem, praw, pact, ptgt, ramp, vact, vtgt} = '0;
      repeat (8) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      chk(status, 16'h1000);
      foreach (ix[k]) acc(1'b0, ix[k], 0, rv[k], 1'b0);
      acc(1'b0, 16'h6071, 0, 32'h0000_0000, 1'b1);
      acc(1'b1, `MWM_IDX_POS_ACTUAL, 32'h0000_1111, 0, 1'b1);
      acc(1'b1, `MWM_IDX_FERR_WINDOW, 32'h0000_0010, 0, 1'b0);
      acc(1'b1, `MWM_IDX_FERR_TIMEOUT, 32'h0000_0002, 0, 1'b0);
      acc(1'b1, `MWM_IDX_POS_WIN_TIME, 32'h0000_0001, 0, 1'b0);
      acc(1'b0, `MWM_IDX_FERR_TIMEOUT, 0, 32'h0000_0002, 1'b0);
      $display("test 1 done");
      pdem <= 32'h0000_0100;
      pact <= 32'h0000_0111;
      repeat (5) @(posedge clk_sys_i);
      chk(status[13], 1'b0);
      wait_bit(13, 1'b1, 40);
      chk({react, log_e}, 2'b11);
      pact <= 32'h0000_0110;
      wait_bit(13, 1'b0, 4);
      // No reaction set up, so the next error must stay silent
      cfg <= 16'h0000;
      pact <= 32'h0000_00EF;
      wait_bit(13, 1'b1, 40);
      chk({react, log_e}, 2'b00);
      acc(1'b1, `MWM_IDX_FERR_WINDOW, `MWM_WINDOW_OFF, 0, 1'b0);
      repeat (40) @(posedge clk_sys_i);
      chk(status[13], 1'b0);
      $display("test 2 done");
      ptgt <= 32'h0000_0100;
      pact <= 32'h0000_0109;
      wait_bit(10, 1'b1, 40);
      pact <= 32'h0000_00F6;
      wait_bit(10, 1'b0, 4);
      mode <= `MWM_MODE_IP;
      pact <= 32'h0000_00F7;
      wait_bit(10, 1'b1, 40);
      acc(1'b1, `MWM_IDX_POS_WINDOW, `MWM_WINDOW_OFF, 0, 1'b0);
      wait_bit(10, 1'b0, 10);
      $display("test 3 done");
      mode <= `MWM_MODE_PV;
      vtgt <= 32'd1000;
      vact <= 32'd1029;
      acc(1'b1, `MWM_IDX_VEL_WIN_TIME, 32'h0000_0001, 0, 1'b0);
      wait_bit(10, 1'b1, 40);
      acc(1'b1, `MWM_IDX_VEL_THRESH, 32'h0000_0100, 0, 1'b0);
      acc(1'b1, `MWM_IDX_VEL_THR_TIME, 32'h0000_0002, 0, 1'b0);
      wait_bit(12, 1'b0, 40);
      vact <= 32'h0000_0100;
      wait_bit(12, 1'b1, 6);
      vact <= 32'd1000;
      mode <= `MWM_MODE_PP;
      repeat (40) @(posedge clk_sys_i);
      chk(status[12], 1'b1);
      $display("test 4 done");
      praw <= 32'h8000_0005;
      pact <= 32'h0000_0055;
      ramp <= 32'h1234_5678;
      homing <= 1'b1;
      acc(1'b0, `MWM_IDX_POS_ACT_RAW, 0, 32'h8000_0005, 1'b0);
      acc(1'b0, `MWM_IDX_POS_ACTUAL, 0, 32'h0000_0000, 1'b0);
      acc(1'b0, `MWM_IDX_VEL_DEMAND, 0, 32'h1234_5678, 1'b0);
      chk(setp, 32'h1234_5678);
      enc_zero <= 1'b1;
      acc(1'b0, `MWM_IDX_POS_ACT_RAW, 0, 32'h0000_0000, 1'b0);
      chk({31'b0, raw_valid}, 32'h0000_0000);
      $display("test 5 done");
      give_verdict();
   end
endmodule // mwm_top_tb
`default_nettype wire
